// ==== design/pch_pkg.sv ====
// Shared constants and types for the slave health monitor.
package pch_pkg;
  localparam int NSLOT = 5;
  localparam int ID_W = 11;
  localparam int NODE_W = 7;
  localparam int CNT_W = 16;
  localparam int MS_W = 16;
  localparam int PDO_W = 64;
  localparam int ADDR_W = 9;
  localparam int LEN_W = 9;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [LEN_W-1:0] IMG_MAX = 9'h110;
  localparam logic [ADDR_W-1:0] STAT_BASE = 9'h000;
  localparam logic [ADDR_W-1:0] HEALTH_BASE = 9'h004;
  localparam logic [ADDR_W-1:0] PDO_BASE = 9'h014;
  localparam logic [ADDR_W-1:0] RAW_BASE = 9'h03c;
  localparam logic [ADDR_W-1:0] RAW_END = 9'h046;
  localparam int RAW_EN_BIT = 0;
  localparam logic [ID_W-1:0] SYNC_ID = 11'h080;
  localparam logic [3:0] FC_TPDO1 = 4'h3;
  localparam logic [3:0] FC_TPDO2 = 4'h5;
  localparam logic [3:0] FC_TPDO3 = 4'h7;
  localparam logic [3:0] FC_TPDO4 = 4'h9;
  typedef enum logic {ST_HEALTHY, ST_LOST} pch_slot_e;
endpackage : pch_pkg

// ==== design/pch_sync.sv ====
// Millisecond tick and periodic SYNC producer.
`timescale 1ns/1ps
`default_nettype none
module pch_sync #(
  parameter int TICK_CYCLES = pch_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Period in ms, zero stops production
  input wire logic [pch_pkg::MS_W-1:0] i_period_ms,
  // Transmit handshake
  input wire logic i_sync_ack,
  output logic o_sync_req,
  output logic [pch_pkg::ID_W-1:0] o_sync_id,
  // Free-running tick
  output logic o_ms_tick
);
  typedef struct packed {
    logic [31:0] div;
    logic tick;
    logic [pch_pkg::MS_W-1:0] ms;
    logic req;
  } pch_sync_s;

  pch_sync_s s;
  pch_sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.div == 32'(TICK_CYCLES - 1)) begin
      next_s.div = 32'h0000_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 32'h0000_0001;
    end
    if (s.req && i_sync_ack) begin
      next_s.req = 1'b0;
    end
    // A new period wins over an acknowledge in the same cycle.
    if (next_s.tick && i_period_ms != '0) begin
      if (s.ms + 16'h0001 >= i_period_ms) begin
        next_s.ms = 16'h0000;
        next_s.req = 1'b1;
      end else begin
        next_s.ms = s.ms + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_ms_tick = s.tick;
  assign o_sync_req = s.req;
  assign o_sync_id = pch_pkg::SYNC_ID;

  sync_on_tick_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(s.req) |-> s.tick && $past(i_period_ms) != '0)
    else $error("SYNC request raised off a period boundary");
endmodule : pch_sync
`default_nettype wire

// ==== design/pch_slot.sv ====
// Per-slave message counter, held process data and health tracking.
`timescale 1ns/1ps
`default_nettype none
module pch_slot (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Received transmit-PDO from this slave
  input wire logic i_rx_hit,
  input wire logic [pch_pkg::PDO_W-1:0] i_rx_data,
  // Timing and scan
  input wire logic i_ms_tick,
  input wire logic i_scan,
  // Configuration
  input wire logic i_use_cnt,
  input wire logic i_guard_ok,
  input wire logic [pch_pkg::MS_W-1:0] i_timeout_ms,
  // Results
  output logic [pch_pkg::CNT_W-1:0] o_count,
  output logic [pch_pkg::PDO_W-1:0] o_data,
  output logic o_healthy,
  output logic o_lost_ev,
  output logic o_add_ev
);
  typedef struct packed {
    logic [pch_pkg::CNT_W-1:0] cnt;
    logic [pch_pkg::CNT_W-1:0] prev;
    logic [pch_pkg::MS_W-1:0] elapsed;
    logic [pch_pkg::PDO_W-1:0] data;
    pch_pkg::pch_slot_e st;
    logic lost_ev;
    logic add_ev;
  } pch_slot_s;

  pch_slot_s s;
  pch_slot_s next_s;

  always_comb begin
    next_s = s;
    next_s.lost_ev = 1'b0;
    next_s.add_ev = 1'b0;
    if (i_rx_hit) begin
      next_s.cnt = s.cnt + 16'h0001;
      next_s.data = i_rx_data;
    end
    // The elapsed time saturates so a long outage cannot wrap to healthy.
    if (i_ms_tick && s.elapsed != '1) begin
      next_s.elapsed = s.elapsed + 16'h0001;
    end
    if (i_scan && i_use_cnt) begin
      if (s.cnt != s.prev) begin
        next_s.prev = s.cnt;
        next_s.elapsed = 16'h0000;
        if (s.st == pch_pkg::ST_LOST) begin
          next_s.st = pch_pkg::ST_HEALTHY;
          next_s.add_ev = 1'b1;
        end
      end else if (s.elapsed >= i_timeout_ms &&
                   s.st == pch_pkg::ST_HEALTHY) begin
        next_s.st = pch_pkg::ST_LOST;
        next_s.lost_ev = 1'b1;
      end
    end
    if (!i_use_cnt) begin
      next_s.st = pch_pkg::ST_HEALTHY;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_count = s.cnt;
  assign o_data = s.data;
  assign o_healthy = i_use_cnt ? (s.st == pch_pkg::ST_HEALTHY) : i_guard_ok;
  assign o_lost_ev = s.lost_ev;
  assign o_add_ev = s.add_ev;

  count_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rx_hit |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("Counter did not advance on a received message");
  data_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_rx_hit |=> s.data == $past(s.data))
    else $error("Held process data changed without a message");
  lost_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.lost_ev |-> $past(i_scan) && $past(s.cnt) == $past(s.prev) &&
      $past(s.elapsed) >= $past(i_timeout_ms) && s.st == pch_pkg::ST_LOST)
    else $error("Slave marked lost without a timeout");
  lost_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.lost_ev |-> $past(s.st) == pch_pkg::ST_HEALTHY)
    else $error("Second loss event for a slave already lost");
  add_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_scan) && $past(i_use_cnt) && $past(s.st) == pch_pkg::ST_LOST &&
      $past(s.cnt) != $past(s.prev) |-> s.add_ev && s.elapsed == '0)
    else $error("Recovered slave not marked healthy");
endmodule : pch_slot
`default_nettype wire

// ==== design/pch_monitor.sv ====
// Top of the slave health monitor: decode, scan image and fault log.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each slave has a counter that steps on every transmit-PDO it sends.
// - Only transmit-PDOs received from slaves step counters, never our own.
// - Counter health overrides guarding or heartbeat status when enabled.
// - Each input scan evaluates every slave that uses counter health.
// - Unchanged counter past the timeout marks the slave lost and logs.
// - A lost slave whose counter moves again is healthy, logs an addition.
// - Configuration byte six can add raw counters to the scan image.
// - Only one loss fault is logged per outage of a node.
// - An offline slave keeps presenting its last process data.
// - Loss of one slave leaves every other slave untouched.
// - The block produces SYNC periodically on the bus.
// - Scan images over 272 bytes are rejected with a controller fault.
// - Image starts with 4 status bytes then 16 health bytes.
// - Every bus object is named by an 11-bit identifier.
// - At most five slaves are supported.
module pch_monitor #(
  parameter int TICK_CYCLES = pch_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Received frames from the bus controller
  input wire logic I_RX_VALID,
  input wire logic [pch_pkg::ID_W-1:0] I_RX_ID,
  input wire logic [pch_pkg::PDO_W-1:0] I_RX_DATA,
  // Configuration load
  input wire logic I_CFG_LOAD,
  input wire logic [pch_pkg::NSLOT*pch_pkg::NODE_W-1:0] I_CFG_NODES,
  input wire logic [pch_pkg::NSLOT-1:0] I_CFG_USE_CNT,
  input wire logic [pch_pkg::MS_W-1:0] I_CFG_TIMEOUT_MS,
  input wire logic [7:0] I_CFG_BYTE6,
  input wire logic [pch_pkg::MS_W-1:0] I_CFG_SYNC_MS,
  input wire logic [pch_pkg::LEN_W-1:0] I_CFG_IN_LEN,
  input wire logic [pch_pkg::LEN_W-1:0] I_CFG_OUT_LEN,
  // Guarding or heartbeat status per slave
  input wire logic [pch_pkg::NSLOT-1:0] I_GUARD_OK,
  // Controller input scan
  input wire logic I_SCAN,
  input wire logic [pch_pkg::ADDR_W-1:0] I_SCAN_ADDR,
  output logic [7:0] O_SCAN_DATA,
  // Status
  output logic [pch_pkg::NSLOT-1:0] O_HEALTH,
  output logic O_CFG_VALID,
  output logic O_CTRL_FAULT,
  // Fault log entries
  output logic O_FLT_VALID,
  output logic O_FLT_ADD,
  output logic [pch_pkg::NODE_W-1:0] O_FLT_NODE,
  // SYNC transmit request
  input wire logic I_SYNC_ACK,
  output logic O_SYNC_REQ,
  output logic [pch_pkg::ID_W-1:0] O_SYNC_ID
);
  localparam int NS = pch_pkg::NSLOT;
  localparam int NW = pch_pkg::NODE_W;

  typedef struct packed {
    logic cfg_valid;
    logic cfg_rej;
    logic [NS-1:0][NW-1:0] nodes;
    logic [NS-1:0] use_cnt;
    logic [pch_pkg::MS_W-1:0] timeout_ms;
    logic [7:0] byte6;
    logic [pch_pkg::MS_W-1:0] sync_ms;
    logic [NS-1:0] pend_loss;
    logic [NS-1:0] pend_add;
    logic [15:0] scan_cnt;
    logic ctrl_fault;
    logic flt_valid;
    logic flt_add;
    logic [NW-1:0] flt_node;
    logic [7:0] scan_data;
  } pch_mon_s;

  pch_mon_s s;
  pch_mon_s next_s;

  logic [NS-1:0] rx_hit;
  logic [NS-1:0] health;
  logic [NS-1:0] lost_ev;
  logic [NS-1:0] add_ev;
  logic [NS-1:0][pch_pkg::PDO_W-1:0] slot_data;
  logic [NS-1:0][pch_pkg::CNT_W-1:0] slot_cnt;
  logic ms_tick;
  logic [7:0] rd;

  // Transmit-PDO identifiers carry function codes 3, 5, 7 and 9.
  function automatic logic is_tpdo(input logic [pch_pkg::ID_W-1:0] id);
    logic [3:0] fc;
    fc = id[10:7];
    is_tpdo = (fc == pch_pkg::FC_TPDO1) || (fc == pch_pkg::FC_TPDO2) ||
              (fc == pch_pkg::FC_TPDO3) || (fc == pch_pkg::FC_TPDO4);
  endfunction : is_tpdo

  function automatic logic [2:0] pick_low(input logic [NS-1:0] v);
    pick_low = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_low = 3'(i);
      end
    end
  endfunction : pick_low

  // Frames that we transmit never reach this port, and receive-PDO codes
  // are filtered out as well.
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      rx_hit[i] = I_RX_VALID && s.cfg_valid && is_tpdo(I_RX_ID) &&
                  s.nodes[i] != '0 && I_RX_ID[6:0] == s.nodes[i];
    end
  end

  // Each slave is tracked by its own instance, so nothing couples them.
  for (genvar g = 0; g < NS; g++) begin : g_slot
    pch_slot u_slot (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_rx_hit(rx_hit[g]),
      .i_rx_data(I_RX_DATA),
      .i_ms_tick(ms_tick),
      .i_scan(I_SCAN),
      .i_use_cnt(s.use_cnt[g]),
      .i_guard_ok(I_GUARD_OK[g]),
      .i_timeout_ms(s.timeout_ms),
      .o_count(slot_cnt[g]),
      .o_data(slot_data[g]),
      .o_healthy(health[g]),
      .o_lost_ev(lost_ev[g]),
      .o_add_ev(add_ev[g])
    );
  end

  pch_sync #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_period_ms(s.cfg_valid ? s.sync_ms : 16'h0000),
    .i_sync_ack(I_SYNC_ACK),
    .o_sync_req(O_SYNC_REQ),
    .o_sync_id(O_SYNC_ID),
    .o_ms_tick(ms_tick)
  );

  // Scan image byte for the requested address.
  always_comb begin : scan_mux
    logic [pch_pkg::ADDR_W-1:0] off;
    logic [2:0] idx;
    off = '0;
    idx = '0;
    rd = 8'h00;
    if (I_SCAN_ADDR < pch_pkg::HEALTH_BASE) begin
      off = I_SCAN_ADDR - pch_pkg::STAT_BASE;
      if (off[1:0] == 2'h0) begin
        rd = {6'h00, s.cfg_rej, s.cfg_valid};
      end else if (off[1:0] == 2'h1) begin
        rd = {3'h0, s.use_cnt & ~health};
      end else if (off[1:0] == 2'h2) begin
        rd = s.scan_cnt[7:0];
      end else begin
        rd = s.scan_cnt[15:8];
      end
    end else if (I_SCAN_ADDR < pch_pkg::PDO_BASE) begin
      off = I_SCAN_ADDR - pch_pkg::HEALTH_BASE;
      for (int i = 0; i < NS; i++) begin
        if (s.nodes[i] != '0 && s.nodes[i][6:3] == off[3:0]) begin
          rd[s.nodes[i][2:0]] = rd[s.nodes[i][2:0]] | health[i];
        end
      end
    end else if (I_SCAN_ADDR < pch_pkg::RAW_BASE) begin
      off = I_SCAN_ADDR - pch_pkg::PDO_BASE;
      idx = off[5:3];
      if (idx < 3'(NS)) begin
        rd = slot_data[idx][{off[2:0], 3'h0} +: 8];
      end
    end else if (I_SCAN_ADDR < pch_pkg::RAW_END &&
                 s.byte6[pch_pkg::RAW_EN_BIT]) begin
      off = I_SCAN_ADDR - pch_pkg::RAW_BASE;
      idx = 3'(off[3:1]);
      if (idx < 3'(NS)) begin
        rd = off[0] ? slot_cnt[idx][15:8] : slot_cnt[idx][7:0];
      end
    end
  end

  // Configuration, fault serialisation and output registers.
  always_comb begin : next_state
    logic [NS-1:0] pl;
    logic [NS-1:0] pa;
    logic [2:0] sel;
    pl = s.pend_loss;
    pa = s.pend_add;
    sel = 3'h0;
    next_s = s;
    next_s.ctrl_fault = 1'b0;
    next_s.flt_valid = 1'b0;
    if (I_CFG_LOAD) begin
      if (I_CFG_IN_LEN > pch_pkg::IMG_MAX ||
          I_CFG_OUT_LEN > pch_pkg::IMG_MAX) begin
        next_s.cfg_rej = 1'b1;
        next_s.ctrl_fault = 1'b1;
      end else begin
        next_s.cfg_valid = 1'b1;
        next_s.cfg_rej = 1'b0;
        next_s.nodes = I_CFG_NODES;
        next_s.use_cnt = I_CFG_USE_CNT;
        next_s.timeout_ms = I_CFG_TIMEOUT_MS;
        next_s.byte6 = I_CFG_BYTE6;
        next_s.sync_ms = I_CFG_SYNC_MS;
      end
    end
    if (I_SCAN) begin
      next_s.scan_cnt = s.scan_cnt + 16'h0001;
    end
    // Several slaves can change on one scan; entries leave one per cycle.
    if (|pl) begin
      sel = pick_low(pl);
      next_s.flt_valid = 1'b1;
      next_s.flt_add = 1'b0;
      next_s.flt_node = s.nodes[sel];
      pl[sel] = 1'b0;
    end else if (|pa) begin
      sel = pick_low(pa);
      next_s.flt_valid = 1'b1;
      next_s.flt_add = 1'b1;
      next_s.flt_node = s.nodes[sel];
      pa[sel] = 1'b0;
    end
    // New events are ORed after the clear so none is dropped.
    next_s.pend_loss = pl | lost_ev;
    next_s.pend_add = pa | add_ev;
    next_s.scan_data = rd;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign O_SCAN_DATA = s.scan_data;
  assign O_HEALTH = health;
  assign O_CFG_VALID = s.cfg_valid;
  assign O_CTRL_FAULT = s.ctrl_fault;
  assign O_FLT_VALID = s.flt_valid;
  assign O_FLT_ADD = s.flt_add;
  assign O_FLT_NODE = s.flt_node;

  // Checks run one cycle behind the registered outputs that they watch.
  rx_filter_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_RX_VALID && !is_tpdo(I_RX_ID) |=> slot_cnt == $past(slot_cnt))
    else $error("Non transmit-PDO frame stepped a counter");
  cfg_reject_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_CFG_LOAD && (I_CFG_IN_LEN > pch_pkg::IMG_MAX ||
      I_CFG_OUT_LEN > pch_pkg::IMG_MAX) |=>
      O_CTRL_FAULT && s.nodes == $past(s.nodes))
    else $error("Oversized scan image was not rejected");
  cfg_accept_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_CFG_LOAD && I_CFG_IN_LEN <= pch_pkg::IMG_MAX &&
      I_CFG_OUT_LEN <= pch_pkg::IMG_MAX |=> O_CFG_VALID && !O_CTRL_FAULT)
    else $error("Valid configuration was not accepted");
  cfg_hold_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !I_CFG_LOAD |=> s.nodes == $past(s.nodes) &&
      O_CFG_VALID == $past(O_CFG_VALID) && !O_CTRL_FAULT)
    else $error("Configuration changed without a load");
  loss_logged_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    lost_ev != '0 |-> ##[1:10] O_FLT_VALID && !O_FLT_ADD)
    else $error("Loss event never reached the fault log");
  add_logged_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    add_ev != '0 |-> ##[1:10] O_FLT_VALID && O_FLT_ADD)
    else $error("Addition event never reached the fault log");
  event_health_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (lost_ev & health & s.use_cnt) == '0 &&
      (add_ev & ~health & s.use_cnt) == '0)
    else $error("Health bit disagrees with a loss or addition event");
  guard_pass_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    ((O_HEALTH ^ I_GUARD_OK) & ~s.use_cnt) == '0)
    else $error("Guarded slave health differs from its guard status");
  status_byte_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_SCAN_ADDR == pch_pkg::STAT_BASE |=>
      O_SCAN_DATA == {6'h00, $past(s.cfg_rej), $past(s.cfg_valid)})
    else $error("Module status byte misplaced in scan image");
  raw_gate_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_SCAN_ADDR >= pch_pkg::RAW_BASE && !s.byte6[pch_pkg::RAW_EN_BIT] |=>
      O_SCAN_DATA == 8'h00)
    else $error("Raw counters shown while disabled");
  out_range_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_SCAN_ADDR >= pch_pkg::RAW_END |=> O_SCAN_DATA == 8'h00)
    else $error("Scan image byte beyond the end is not zero");
  scan_count_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_SCAN |=> s.scan_cnt == $past(s.scan_cnt) + 16'h0001)
    else $error("Input scan was not counted");
  sync_hold_a: assert property (
    @(posedge I_MCLK) disable iff (!I_RST_N)
    O_SYNC_REQ && !I_SYNC_ACK |=> O_SYNC_REQ)
    else $error("SYNC request dropped before it was taken");
endmodule : pch_monitor
`default_nettype wire

// ==== design/pch_end.sv ====
// Intentionally empty compile unit.

// ==== sim/pch_partner.sv ====
// Slave-side model: sends transmit-PDO frames and takes SYNC requests.
`timescale 1ns/1ps
`default_nettype none
module pch_partner (
  // Clock
  input wire logic i_clk,
  // Frames toward the monitor
  output logic o_rx_valid,
  output logic [pch_pkg::ID_W-1:0] o_rx_id,
  output logic [pch_pkg::PDO_W-1:0] o_rx_data,
  // SYNC handshake
  input wire logic i_sync_req,
  output logic o_sync_ack
);
  int wait_n = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_id = 11'h000;
    o_rx_data = 64'h0;
    o_sync_ack = 1'b0;
  end
  task automatic send(input logic [3:0] fc, input logic [6:0] node,
      input logic [63:0] data);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_id = {fc, node};
    o_rx_data = data;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    // Idle lines show the inverse so a stale frame never looks fresh.
    o_rx_id = ~o_rx_id;
    o_rx_data = ~o_rx_data;
  endtask : send
  // The transmitter alternates between a prompt and a slow acceptance.
  always begin
    @(negedge i_clk);
    if (i_sync_req === 1'b1) begin
      repeat (wait_n) @(negedge i_clk);
      o_sync_ack = 1'b1;
      @(negedge i_clk);
      o_sync_ack = 1'b0;
      wait_n = (wait_n == 0) ? 4 : 0;
    end
  end
endmodule : pch_partner
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the slave health monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_v;
  logic [10:0] rx_id;
  logic [63:0] rx_d;
  logic ld = 1'b0;
  logic [34:0] nodes = {21'h0, 7'h04, 7'h03, 7'h02};
  logic [4:0] use_cnt = 5'h03;
  logic [15:0] tmo = 16'h0003;
  logic [7:0] b6 = 8'h01;
  logic [15:0] sync_ms = 16'h0002;
  logic [8:0] in_len = 9'h110;
  logic [8:0] out_len = 9'h110;
  logic [4:0] guard = 5'h1f;
  logic scan = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] sdata;
  logic [7:0] d;
  logic [4:0] health;
  logic cfg_v, cfault, fv, fadd, ack, sreq, sreq_q, ladd;
  logic [6:0] fnode, lnode;
  logic [10:0] sid;
  int failures = 0;
  int checks_done = 0;
  int nflt = 0;
  int nctl = 0;
  int nsync = 0;
  int n0;

  // One millisecond is ten clocks here to keep timeouts short.
  pch_monitor #(.TICK_CYCLES(10)) i_dut (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_RX_VALID(rx_v), .I_RX_ID(rx_id),
    .I_RX_DATA(rx_d), .I_CFG_LOAD(ld), .I_CFG_NODES(nodes),
    .I_CFG_USE_CNT(use_cnt), .I_CFG_TIMEOUT_MS(tmo), .I_CFG_BYTE6(b6),
    .I_CFG_SYNC_MS(sync_ms), .I_CFG_IN_LEN(in_len),
    .I_CFG_OUT_LEN(out_len), .I_GUARD_OK(guard), .I_SCAN(scan),
    .I_SCAN_ADDR(addr), .O_SCAN_DATA(sdata), .O_HEALTH(health),
    .O_CFG_VALID(cfg_v), .O_CTRL_FAULT(cfault), .O_FLT_VALID(fv),
    .O_FLT_ADD(fadd), .O_FLT_NODE(fnode), .I_SYNC_ACK(ack),
    .O_SYNC_REQ(sreq), .O_SYNC_ID(sid));
  pch_partner i_slv (.i_clk(clk), .o_rx_valid(rx_v), .o_rx_id(rx_id),
    .o_rx_data(rx_d), .i_sync_req(sreq), .o_sync_ack(ack));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    sreq_q <= sreq;
    if (sreq === 1'b1 && sreq_q !== 1'b1) nsync++;
    if (cfault === 1'b1) nctl++;
    if (fv === 1'b1) begin
      nflt++;
      ladd = fadd;
      lnode = fnode;
    end
  end

  task automatic rd(input logic [8:0] a);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = sdata;
  endtask : rd
  task automatic do_scan;
    @(negedge clk);
    scan = 1'b1;
    @(negedge clk);
    scan = 1'b0;
    repeat (6) @(negedge clk);
  endtask : do_scan
  task automatic load(input logic [8:0] li, input logic [8:0] lo);
    @(negedge clk);
    in_len = li;
    out_len = lo;
    ld = 1'b1;
    @(negedge clk);
    ld = 1'b0;
    repeat (3) @(negedge clk);
  endtask : load
  task automatic feed_node3;
    repeat (4) begin
      repeat (8) @(negedge clk);
      i_slv.send(pch_pkg::FC_TPDO2, 7'h03, 64'h33);
    end
  endtask : feed_node3

  task automatic t_cfg;
    load(9'h111, 9'h110);
    load(9'h110, 9'h111);
    `CHK("ctrl faults", 2, nctl)
    `CHK("cfg valid", 1'b0, cfg_v)
    rd(9'h000);
    `CHK("status rejected", 8'h02, d)
    load(9'h110, 9'h110);
    `CHK("cfg valid", 1'b1, cfg_v)
    `CHK("ctrl faults", 2, nctl)
    rd(9'h000);
    `CHK("status ok", 8'h01, d)
  endtask : t_cfg

  task automatic t_count;
    i_slv.send(pch_pkg::FC_TPDO1, 7'h02, 64'h11);
    i_slv.send(pch_pkg::FC_TPDO4, 7'h02, 64'h22);
    i_slv.send(pch_pkg::FC_TPDO2, 7'h03, 64'h33);
    i_slv.send(pch_pkg::FC_TPDO3, 7'h03, 64'h33);
    i_slv.send(4'h4, 7'h02, 64'h55);
    i_slv.send(pch_pkg::FC_TPDO1, 7'h05, 64'h55);
    i_slv.send(pch_pkg::FC_TPDO1, 7'h00, 64'h66);
    rd(9'h03c);
    `CHK("raw cnt0 lo", 8'h02, d)
    rd(9'h03d);
    `CHK("raw cnt0 hi", 8'h00, d)
    rd(9'h03e);
    `CHK("raw cnt1", 8'h02, d)
    rd(9'h042);
    `CHK("raw cnt3", 8'h00, d)
    rd(9'h014);
    `CHK("slot0 data", 8'h22, d)
    n0 = nflt;
    do_scan();
    do_scan();
    `CHK("health early", 2'b11, health[1:0])
    `CHK("no early fault", n0, nflt)
  endtask : t_count

  task automatic t_loss;
    n0 = nflt;
    feed_node3();
    do_scan();
    `CHK("health lost", 2'b10, health[1:0])
    `CHK("loss entries", n0 + 1, nflt)
    `CHK("loss kind", 1'b0, ladd)
    `CHK("loss node", 7'h02, lnode)
    rd(9'h001);
    `CHK("lost mask", 8'h01, d)
    rd(9'h004);
    `CHK("health byte", 2'b10, d[3:2])
    rd(9'h014);
    `CHK("held data", 8'h22, d)
    rd(9'h03e);
    `CHK("live cnt1", 8'h06, d)
    feed_node3();
    do_scan();
    `CHK("single loss", n0 + 1, nflt)
    `CHK("still lost", 2'b10, health[1:0])
  endtask : t_loss

  task automatic t_add;
    n0 = nflt;
    i_slv.send(pch_pkg::FC_TPDO1, 7'h02, 64'h44);
    do_scan();
    `CHK("health back", 1'b1, health[0])
    `CHK("add entries", n0 + 1, nflt)
    `CHK("add kind", 1'b1, ladd)
    `CHK("add node", 7'h02, lnode)
    rd(9'h014);
    `CHK("new data", 8'h44, d)
    rd(9'h03c);
    `CHK("raw cnt0", 8'h03, d)
    rd(9'h002);
    `CHK("scan count lo", 8'h05, d)
    rd(9'h003);
    `CHK("scan count hi", 8'h00, d)
  endtask : t_add

  task automatic t_guard;
    @(negedge clk);
    guard = 5'h1a;
    @(negedge clk);
    `CHK("cnt over guard", 1'b1, health[0])
    `CHK("guard slot", 1'b0, health[2])
    guard = 5'h1f;
    @(negedge clk);
    `CHK("guard slot", 1'b1, health[2])
  endtask : t_guard

  task automatic t_sync;
    n0 = nsync;
    repeat (200) @(negedge clk);
    `CHK("sync rate", 1'b1, (nsync - n0 >= 9) && (nsync - n0 <= 11))
    `CHK("sync id", 11'h080, sid)
    b6 = 8'h00;
    sync_ms = 16'h0000;
    load(9'h110, 9'h110);
    rd(9'h03c);
    `CHK("raw off", 8'h00, d)
    rd(9'h046);
    `CHK("past image end", 8'h00, d)
    n0 = nsync;
    repeat (60) @(negedge clk);
    `CHK("sync stopped", n0, nsync)
  endtask : t_sync

  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // The scenarios need well under a thousand clocks; six thousand is a hang.
  initial begin
    #(25 * 6000);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_cfg();
    t_count();
    t_loss();
    t_add();
    t_guard();
    t_sync();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
